// *** design/mssup_pkg.sv ***
package mssup_pkg;

    // ****************************************
    // widths and fixed figures
    // ****************************************
    localparam int CUR_W = 16;
    localparam int TMR_W = 24;
    localparam int CLK_MHZ = 100;
    // processing tick period in ns; a short tick keeps runs brief
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
    localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);
    // start threshold in percent of full load
    localparam logic [7:0] START_PCT = 8'h1e;
    localparam logic [7:0] PCT_FULL = 8'h64;
    // transient filter on report-back: 0.5 s, held in ticks
    localparam int DEGLITCH_NS = 500000000;
    localparam logic [TMR_W-1:0] DEGLITCH_TICKS =
        TMR_W'(DEGLITCH_NS / TICK_NS);
    localparam int REVERSE_NS = 100000000;
    localparam logic [TMR_W-1:0] REVERSE_TICKS =
        TMR_W'(REVERSE_NS / TICK_NS);
    localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
    localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

    typedef enum logic [1:0] {
        CRIT_TIME_ONLY = 2'h0,
        CRIT_CURRENT_ONLY = 2'h1,
        CRIT_TIME_OR_CURRENT = 2'h2,
        CRIT_TIME_AND_CURRENT = 2'h3
    } mssup_crit_type;

    typedef enum logic [3:0] {
        ST_STOP = 4'h1,
        ST_START = 4'h2,
        ST_RUN = 4'h4,
        ST_TRIP = 4'h8
    } mssup_state_type;

    typedef struct packed {
        logic [CUR_W-1:0] phaseA;
        logic [CUR_W-1:0] phaseB;
        logic [CUR_W-1:0] phaseC;
    } mssup_cur_type;

    // time settings in ticks, current levels in current units
    typedef struct packed {
        mssup_crit_type transitionCriterion;
        logic [CUR_W-1:0] fullLoadCurrent;
        logic [CUR_W-1:0] transitionCurrentLevel;
        logic [CUR_W-1:0] stopCurrentThreshold;
        logic [TMR_W-1:0] transitionTimer;
        logic [TMR_W-1:0] lockedRotorTime;
        logic [TMR_W-1:0] sequenceTimeLimit;
        logic [TMR_W-1:0] antiBackspinDelay;
        logic sequenceCheckSelect;
        logic sequenceEnable;
        logic zeroSpeedEnable;
        logic reversingAllowed;
        logic antiBackspinEnable;
    } mssup_cfg_type;

    typedef struct packed {
        logic transitionTripFlag;
        logic sequenceFailStartToRun;
        logic sequenceFailStopToStart;
        logic zeroSpeedTripFlag;
        logic phaseReverseTripFlag;
        logic transitionByTime;
        logic transitionByCurrent;
    } mssup_flag_type;

endpackage

// *** design/mssup_supervisor.sv ***
// Functional notes
// R1: any setting change restarts the block and forces state to stop.
// R2: after restart a running motor re-cycles, counters held, timers reset.
// R3: four states; stop-start-run-stop, plus start-stop, start-trip, run-trip.
// R4: external trip in start or run forces trip; leave when currents cease.
// R5: failed start-control transition trips with transition trip flag.
// R6: sequence trip raises start-to-run or stop-to-start flag by select.
// R7: zero-speed switch not open within locked-rotor time trips.
// R8: reverse rotation at start with reversing disallowed trips.
// R9: trip contact closed whenever not in trip state.
// R10: outside control energises contactor; the block never commands start.
// R11: start declared above 30% of full load; transition timer starts.
// R12: in start, flag when current falls below transition level.
// R13: time-only criterion enters run when the timer expires.
// R14: current-only enters run on current drop; trips on timer expiry.
// R15: time-or-current enters run on whichever comes first.
// R16: time-and-current needs drop before expiry, then run; else trip.
// R17: successful transition sets time and/or current cause flags.
// R18: suggested time-or-current, 130% level, long transition timer.
// R19: run lasts until all three phases are below stop threshold.
// R20: on stop, anti-backspin blocks new start and counts down; it is not armed on the first stop after a restart.
// R21: report-back must energise before its time limit or trip.
// R22: after limit, report-back loss over 0.5 s trips; shorter ignored.
// R23: reverse trip and trip command about 100 ms after start.
// R24: start detect uses largest phase magnitude once per tick.
module mssup_supervisor
    import mssup_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire mssup_cur_type phaseCurrent,
    input wire mssup_cfg_type cfg,
    input wire logic otherTrip,
    input wire logic reportBackInput,
    input wire logic zeroSpeedSwitch,
    input wire logic reverseRotation,
    input wire logic startCounterHold,
    output mssup_state_type motorState,
    output mssup_flag_type flags,
    output logic tripCommand,
    output logic tripContactClosed,
    output logic currentBelowTransition,
    output logic startBlocked,
    output logic [TMR_W-1:0] blockRemaining,
    output logic restartPulse,
    output logic countStart
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [CUR_W-1:0] maxOf(
        input logic [CUR_W-1:0] a,
        input logic [CUR_W-1:0] b
    );
        maxOf = (a > b) ? a : b;
    endfunction

    function automatic logic [TMR_W-1:0] countUp(
        input logic [TMR_W-1:0] v
    );
        countUp = (v == {TMR_W{1'b1}}) ? v : v + TMR_ONE;
    endfunction

    // ****************************************
    // tick and setting change
    // ****************************************
    logic [19:0] tickCnt_q;
    mssup_cfg_type cfg_q;
    logic cfgValid_q;
    wire logic tick = (tickCnt_q == TICK_LAST);
    // R1: restart on change
    wire logic cfgChanged = cfgValid_q && (cfg != cfg_q);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tickCnt_q <= 20'h00000;
            cfg_q <= '0;
            cfgValid_q <= 1'b0;
        end else begin
            tickCnt_q <= tick ? 20'h00000 : tickCnt_q + 20'h00001;
            cfg_q <= cfg;
            cfgValid_q <= 1'b1;
        end
    end

    // ****************************************
    // current comparisons
    // ****************************************
    // R24: largest phase
    wire logic [CUR_W-1:0] peak =
        maxOf(maxOf(phaseCurrent.phaseA, phaseCurrent.phaseB),
              phaseCurrent.phaseC);
    // scaled compare avoids a divider: peak*100 > fla*30
    wire logic [CUR_W+7:0] peakScaled = peak * PCT_FULL;
    wire logic [CUR_W+7:0] startLevel = cfg.fullLoadCurrent * START_PCT;
    // R11: start threshold
    wire logic startSeen = peakScaled > startLevel;
    wire logic belowTrn = peak < cfg.transitionCurrentLevel;
    // R19: all phases under
    wire logic allStopped =
        (phaseCurrent.phaseA < cfg.stopCurrentThreshold) &&
        (phaseCurrent.phaseB < cfg.stopCurrentThreshold) &&
        (phaseCurrent.phaseC < cfg.stopCurrentThreshold);

    // ****************************************
    // state machine
    // ****************************************
    mssup_state_type state_d, state_q;
    logic [TMR_W-1:0] startTmr_q;
    logic [TMR_W-1:0] seqTmr_q;
    logic [TMR_W-1:0] lossTmr_q;
    logic [TMR_W-1:0] absTmr_q;
    logic dropSeen_q;
    logic restarted_q;
    mssup_flag_type flags_q, flags_d;

    wire logic inStart = (state_q == ST_START);
    wire logic inRun = (state_q == ST_RUN);
    wire logic timerDone = startTmr_q >= cfg.transitionTimer;
    // R12: drop seen in start
    wire logic dropNow = inStart && belowTrn;
    wire logic dropAny = dropSeen_q || dropNow;

    // R13: time-only
    // R14: current-only
    // R15: time-or-current
    // R16: time-and-current
    logic toRun, trnFail;
    always_comb begin
        toRun = 1'b0;
        trnFail = 1'b0;
        unique case (cfg.transitionCriterion)
            CRIT_TIME_ONLY: toRun = timerDone;
            CRIT_CURRENT_ONLY: begin
                toRun = dropNow && !timerDone;
                // expiry wins a tie, else the machine would stall
                trnFail = timerDone;
            end
            CRIT_TIME_OR_CURRENT: toRun = timerDone || dropNow;
            CRIT_TIME_AND_CURRENT: begin
                toRun = timerDone && dropAny;
                trnFail = timerDone && !dropAny;
            end
        endcase
    end

    // R7: zero-speed check
    wire logic zssFail = inStart && cfg.zeroSpeedEnable && zeroSpeedSwitch &&
        (startTmr_q >= cfg.lockedRotorTime);
    // R8: reverse at start
    // R23: delayed reverse trip
    wire logic revFail = inStart && !cfg.reversingAllowed &&
        reverseRotation && (startTmr_q >= REVERSE_TICKS);
    // R21: report-back limit
    wire logic seqLimitPast = seqTmr_q >= cfg.sequenceTimeLimit;
    wire logic seqLate = cfg.sequenceEnable && (inStart || inRun) &&
        seqLimitPast && !reportBackInput && (lossTmr_q == TMR_ZERO) &&
        (seqTmr_q == cfg.sequenceTimeLimit);
    // R22: filtered loss
    wire logic seqLost = cfg.sequenceEnable && (inStart || inRun) &&
        seqLimitPast && (lossTmr_q >= DEGLITCH_TICKS);
    wire logic seqFail = seqLate || seqLost;
    // R5: transition trip
    wire logic startTrip = inStart && tick && trnFail;
    wire logic anyTrip = startTrip || (tick && (zssFail || revFail ||
        seqFail)) || ((inStart || inRun) && otherTrip);

    // R3: state transitions
    // R4: trip handling
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_STOP: if (tick && startSeen && !startBlocked) state_d = ST_START;
            ST_START: begin
                if (anyTrip) state_d = ST_TRIP;
                else if (tick && allStopped) state_d = ST_STOP;
                else if (tick && toRun) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (anyTrip) state_d = ST_TRIP;
                else if (tick && allStopped) state_d = ST_STOP;
            end
            ST_TRIP: if (tick && allStopped) state_d = ST_STOP;
            default: state_d = ST_STOP;
        endcase
    end

    // R17: cause flags
    always_comb begin
        flags_d = flags_q;
        if (state_q == ST_STOP && state_d == ST_START) flags_d = '0;
        if (inStart && state_d == ST_RUN) begin
            flags_d.transitionByTime = timerDone;
            flags_d.transitionByCurrent = dropNow;
        end
        if (startTrip) flags_d.transitionTripFlag = 1'b1;
        if (tick && zssFail) flags_d.zeroSpeedTripFlag = 1'b1;
        if (tick && revFail) flags_d.phaseReverseTripFlag = 1'b1;
        // R6: select picks flag
        if (tick && seqFail) begin
            if (cfg.sequenceCheckSelect) flags_d.sequenceFailStopToStart = 1'b1;
            else flags_d.sequenceFailStartToRun = 1'b1;
        end
    end

    wire logic enterStop = (state_q != ST_STOP) && (state_d == ST_STOP);
    wire logic enterStart = (state_q == ST_STOP) && (state_d == ST_START);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_STOP;
            flags_q <= '0;
            dropSeen_q <= 1'b0;
            restarted_q <= 1'b0;
        end else if (cfgChanged) begin
            // R1: forced back to stop
            // R2: flags and timers cleared
            state_q <= ST_STOP;
            flags_q <= '0;
            dropSeen_q <= 1'b0;
            restarted_q <= 1'b1;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            dropSeen_q <= inStart && dropAny;
            if (enterStop) restarted_q <= 1'b0;
        end
    end

    // ****************************************
    // timers, all per tick
    // ****************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            startTmr_q <= TMR_ZERO;
            seqTmr_q <= TMR_ZERO;
            lossTmr_q <= TMR_ZERO;
            absTmr_q <= TMR_ZERO;
        end else if (cfgChanged) begin
            startTmr_q <= TMR_ZERO;
            seqTmr_q <= TMR_ZERO;
            lossTmr_q <= TMR_ZERO;
            absTmr_q <= TMR_ZERO;
        end else begin
            // R11: timer starts with start
            if (enterStart) startTmr_q <= TMR_ZERO;
            else if (tick && inStart) startTmr_q <= countUp(startTmr_q);
            if (enterStart) seqTmr_q <= TMR_ZERO;
            else if (tick && (inStart || inRun)) seqTmr_q <= countUp(seqTmr_q);
            // R22: short transients ignored
            if (reportBackInput || !(inStart || inRun)) lossTmr_q <= TMR_ZERO;
            else if (tick && seqLimitPast) lossTmr_q <= countUp(lossTmr_q);
            // R20: backspin countdown
            if (enterStop && cfg.antiBackspinEnable && !restarted_q)
                absTmr_q <= cfg.antiBackspinDelay;
            else if (tick && absTmr_q != TMR_ZERO)
                absTmr_q <= absTmr_q - TMR_ONE;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic tripCmd_q;
    logic countStart_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tripCmd_q <= 1'b0;
            countStart_q <= 1'b0;
        end else begin
            tripCmd_q <= !cfgChanged && (state_d == ST_TRIP);
            // R2: no count after restart
            countStart_q <= !cfgChanged && enterStart && !restarted_q &&
                !startCounterHold;
        end
    end

    assign motorState = state_q;
    assign flags = flags_q;
    assign tripCommand = tripCmd_q;
    // R9: contact closed unless tripped
    assign tripContactClosed = !tripCmd_q;
    assign currentBelowTransition = dropSeen_q;
    // R20: block while counting
    assign startBlocked = (absTmr_q != TMR_ZERO);
    assign blockRemaining = absTmr_q;
    assign restartPulse = cfgChanged;
    assign countStart = countStart_q;

endmodule

// *** verif/mssup_contact_model.sv ***
module mssup_contact_model
    import mssup_pkg::*;
(
    input wire logic energise,
    input wire logic [CUR_W-1:0] level,
    input wire logic [1:0] hotPhase,
    output mssup_cur_type phaseCurrent,
    output logic reportBackInput,
    output logic zeroSpeedSwitch
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // contactor and process contacts
    // ****************************************
    // small leakage on idle phases, so only the max can start
    localparam logic [CUR_W-1:0] IDLE_CUR = 16'h0008;
    logic [CUR_W-1:0] lowCur;
    // only outside control closes the contactor
    assign lowCur = energise ? IDLE_CUR : 16'h0000;
    assign phaseCurrent.phaseA = (energise && hotPhase == 2'h0) ? level : lowCur;
    assign phaseCurrent.phaseB = (energise && hotPhase == 2'h1) ? level : lowCur;
    assign phaseCurrent.phaseC = (energise && hotPhase == 2'h2) ? level : lowCur;
    assign reportBackInput = energise;
    assign zeroSpeedSwitch = !energise;
endmodule

// *** verif/mssup_checker_sva.sv ***
module mssup_checker_sva
    import mssup_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic otherTrip,
    input wire mssup_state_type motorState,
    input wire mssup_flag_type flags,
    input wire logic tripCommand,
    input wire logic tripContactClosed,
    input wire logic restartPulse,
    input wire logic countStart
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // state machine checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence enterStart;
        motorState == ST_START && $past(motorState) == ST_STOP;
    endsequence
    sequence enterRun;
        motorState == ST_RUN && $past(motorState) == ST_START;
    endsequence
    contact_inverse_a: assert property (
        tripContactClosed == !tripCommand) else $error("contact level");
    trip_command_a: assert property (
        tripCommand == (motorState == ST_TRIP)) else $error("trip command");
    state_onehot_a: assert property (
        $onehot(motorState)) else $error("state not one-hot");
    stop_exit_a: assert property (
        motorState == ST_STOP |=> motorState inside {ST_STOP, ST_START})
        else $error("bad exit from stop");
    run_exit_a: assert property (
        motorState == ST_RUN |=> motorState != ST_START)
        else $error("run went to start");
    trip_exit_a: assert property (
        motorState == ST_TRIP |=> motorState inside {ST_TRIP, ST_STOP})
        else $error("bad exit from trip");
    other_trip_a: assert property (
        otherTrip && !restartPulse && motorState inside {ST_START, ST_RUN}
        |=> motorState == ST_TRIP) else $error("trip not taken");
    restart_stop_a: assert property (
        restartPulse |=> motorState == ST_STOP) else $error("restart");
    count_start_a: assert property (
        countStart |-> enterStart) else $error("count without start");
    start_clear_a: assert property (
        enterStart |-> !flags.transitionByTime && !flags.transitionByCurrent)
        else $error("cause flags stale");
    run_cause_a: assert property (
        enterRun |-> flags.transitionByTime || flags.transitionByCurrent)
        else $error("run without cause");
endmodule

bind mssup_supervisor mssup_checker_sva chk (.mclk(mclk), .resetn(resetn),
    .otherTrip(otherTrip), .motorState(motorState), .flags(flags),
    .tripCommand(tripCommand), .tripContactClosed(tripContactClosed),
    .restartPulse(restartPulse), .countStart(countStart));

// *** verif/testbench.sv ***
module testbench;
    import mssup_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // bench
    // ****************************************
    typedef struct packed {mssup_state_type st; logic cnt;} mssup_note_type;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic otherTrip = 1'b0;
    logic energise = 1'b0;
    logic reverseRotation = 1'b0;
    logic startCounterHold = 1'b0;
    logic [CUR_W-1:0] level = 16'h0000;
    logic [1:0] hotPhase = 2'h0;
    mssup_cfg_type cfg = '0;
    mssup_cur_type phaseCurrent;
    logic reportBackInput, zeroSpeedSwitch, tripCommand, tripContactClosed;
    logic currentBelowTransition, startBlocked, restartPulse, countStart;
    mssup_state_type motorState;
    mssup_flag_type flags;
    mssup_state_type prevState = ST_STOP;
    mssup_note_type notes[$];
    int fail_count = 0;
    int checks_done = 0;
    int rnd;

    always #5 mclk = ~mclk;

    mssup_contact_model model (.energise(energise), .level(level),
        .hotPhase(hotPhase), .phaseCurrent(phaseCurrent),
        .reportBackInput(reportBackInput), .zeroSpeedSwitch(zeroSpeedSwitch));

    mssup_supervisor dut (.mclk(mclk), .resetn(resetn),
        .phaseCurrent(phaseCurrent), .cfg(cfg), .otherTrip(otherTrip),
        .reportBackInput(reportBackInput), .zeroSpeedSwitch(zeroSpeedSwitch),
        .reverseRotation(reverseRotation),
        .startCounterHold(startCounterHold), .motorState(motorState),
        .flags(flags), .tripCommand(tripCommand),
        .tripContactClosed(tripContactClosed),
        .currentBelowTransition(currentBelowTransition),
        .startBlocked(startBlocked), .blockRemaining(),
        .restartPulse(restartPulse), .countStart(countStart));

    task check(string name, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (exp !== got) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a decision lands on a tick; timed criteria need several ticks
    task expect_state(mssup_state_type s, logic c);
        int n;
        notes.push_back('{s, c});
        n = 0;
        while (motorState !== s && n < 8 * TICK_CYC + 20) begin
            @(negedge mclk);
            n++;
        end
        check("state wait", 8'(s), 8'(motorState));
        @(negedge mclk);
    endtask

    always @(negedge mclk) begin
        mssup_note_type note;
        if (resetn && motorState !== prevState) begin
            if (notes.size() == 0) begin
                check("unexpected state", 8'(prevState), 8'(motorState));
            end else begin
                note = notes.pop_front();
                check("motorState", 8'(note.st), 8'(motorState));
                check("countStart", 8'(note.cnt), 8'(countStart));
            end
        end
        prevState = motorState;
    end

    initial begin
        repeat (60 * TICK_CYC) @(posedge mclk);
        fail_count++;
        $display("Error watchdog expected end seen hang");
        results;
    end

    initial begin
        // time-or-current, level near 130%, long timer
        cfg.transitionCriterion = CRIT_TIME_OR_CURRENT;
        cfg.fullLoadCurrent = 16'h0100;
        cfg.transitionCurrentLevel = 16'h014d;
        cfg.stopCurrentThreshold = 16'h0020;
        cfg.transitionTimer = 24'h000064;
        cfg.lockedRotorTime = 24'h000064;
        cfg.reversingAllowed = 1'b1;
        rnd = $urandom(32'ha52e);
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        hotPhase <= 2'($urandom % 3);
        level <= 16'h0200 + 16'($urandom % 128);
        energise <= 1'b1;
        expect_state(ST_START, 1'b1);
        @(posedge mclk) otherTrip <= 1'b1;
        expect_state(ST_TRIP, 1'b0);
        check("tripContactClosed", 8'h00, 8'(tripContactClosed));
        @(posedge mclk) otherTrip <= 1'b0;
        energise <= 1'b0;
        expect_state(ST_STOP, 1'b0);
        check("tripContactClosed", 8'h01, 8'(tripContactClosed));
        @(posedge mclk) energise <= 1'b1;
        expect_state(ST_START, 1'b1);
        @(posedge mclk) level <= 16'h0100 + 16'($urandom % 64);
        expect_state(ST_RUN, 1'b0);
        check("byCurrent", 8'h01, 8'(flags.transitionByCurrent));
        check("byTime", 8'h00, 8'(flags.transitionByTime));
        check("transition_trip_flag", 8'h00, 8'(flags.transitionTripFlag));
        @(posedge mclk) cfg.stopCurrentThreshold <= 16'h0021;
        expect_state(ST_STOP, 1'b0);
        expect_state(ST_START, 1'b0);
        expect_state(ST_RUN, 1'b0);
        @(posedge mclk) energise <= 1'b0;
        expect_state(ST_STOP, 1'b0);
        // time-only; backspin armed on a counted stop
        @(posedge mclk) cfg.transitionCriterion <= CRIT_TIME_ONLY;
        cfg.transitionTimer <= 24'h000003;
        cfg.antiBackspinEnable <= 1'b1;
        cfg.antiBackspinDelay <= 24'h000003;
        level <= 16'h0200;
        energise <= 1'b1;
        expect_state(ST_START, 1'b0);
        expect_state(ST_RUN, 1'b0);
        check("byTime", 8'h01, 8'(flags.transitionByTime));
        check("byCurrent", 8'h00, 8'(flags.transitionByCurrent));
        @(posedge mclk) energise <= 1'b0;
        expect_state(ST_STOP, 1'b0);
        @(posedge mclk) energise <= 1'b1;
        expect_state(ST_START, 1'b1);
        expect_state(ST_RUN, 1'b0);
        @(posedge mclk) energise <= 1'b0;
        expect_state(ST_STOP, 1'b0);
        check("startBlocked", 8'h01, 8'(startBlocked));
        // current-only trips when the timer runs out
        @(posedge mclk) cfg.transitionCriterion <= CRIT_CURRENT_ONLY;
        cfg.transitionTimer <= 24'h000005;
        energise <= 1'b1;
        expect_state(ST_START, 1'b0);
        expect_state(ST_TRIP, 1'b0);
        check("transition_trip_flag", 8'h01, 8'(flags.transitionTripFlag));
        check("tripContactClosed", 8'h00, 8'(tripContactClosed));
        @(posedge mclk) energise <= 1'b0;
        expect_state(ST_STOP, 1'b0);
        results;
    end
endmodule
